// *** inc/tpc_pkg.sv ***
`default_nettype none
package tpc_pkg;

    // ****************************************
    // widths and register map
    // ****************************************
    localparam int          ADR_W     = 8;
    localparam int          CNT_W     = 16;
    localparam int          PRE_W     = 7;
    localparam logic [7:0]  ADR_SC    = 8'h00;
    localparam logic [7:0]  ADR_CNT   = 8'h04;
    localparam logic [7:0]  ADR_MOD   = 8'h08;
    localparam logic [7:0]  ADR_CHCTL = 8'h20;
    localparam logic [7:0]  ADR_CHVAL = 8'h40;
    localparam logic [7:0]  ADR_STEP  = 8'h04;

    // ****************************************
    // status/control fields and reset values
    // ****************************************
    localparam int          SC_TOF    = 7;
    localparam int          SC_OVERFLOW_IRQ_ENABLE   = 6;
    localparam int          SC_CENTER_ALIGN_SELECT  = 5;
    localparam int          SC_CLKS   = 3;
    localparam int          SC_PS     = 0;
    localparam int          CH_ELS    = 0;
    localparam int          CH_MS     = 2;
    localparam logic [7:0]  SC_RST    = 8'h00;
    localparam logic [15:0] MOD_RST   = 16'h0000;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_FREE  = 16'hFFFF;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0]  CLK_OFF   = 2'h0;
    localparam logic [1:0]  CLK_BUS   = 2'h1;
    localparam logic [1:0]  CLK_FIX   = 2'h2;
    localparam logic [1:0]  CLK_EXT   = 2'h3;
    localparam logic [1:0]  ELS_OFF   = 2'h0;
    localparam logic [1:0]  OC_TOGGLE = 2'h1;
    localparam logic [1:0]  OC_CLEAR  = 2'h2;
    localparam logic [1:0]  OC_SET    = 2'h3;
    localparam logic [1:0]  MS_CAPT   = 2'h0;
    localparam logic [1:0]  MS_COMP   = 2'h1;
    localparam int          CAP_MIN_CYC = 4;

    typedef enum logic [2:0] {FN_OFF, FN_CAPTURE, FN_COMPARE, FN_EPWM, FN_CPWM} tpc_func_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] els;
    } tpc_chcfg_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        step;
        logic        upDir;
        logic        center_align_select;
        logic [1:0]  clks;
    } tpc_tmr_t;

endpackage : tpc_pkg
`default_nettype wire

// *** src/tpc_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_channel (
    input  wire logic               clk,      // bus clock
    input  wire logic               reset_n,  // async reset
    input  wire tpc_pkg::tpc_tmr_t  tmr,      // counter state
    input  wire tpc_pkg::tpc_chcfg_t cfg,     // channel config
    input  wire logic [15:0]        value,    // compare value
    input  wire logic               blocked,  // pin taken by ext clock
    input  wire logic               pinIn,    // pin level in
    output logic                    pinOut,   // pin level out
    output logic                    pinOe,    // pin drive enable
    output logic                    capture   // capture pulse
);

    typedef struct packed {
        logic [2:0] sync;
        logic       pin;
        logic       oe;
        logic       cap;
    } tpc_ch_state_t;

    tpc_ch_state_t s_q;
    tpc_ch_state_t s_d;
    tpc_pkg::tpc_func_t fn;
    logic rise;
    logic fall;
    logic match;
    logic start;

    function automatic tpc_pkg::tpc_func_t chFunction(tpc_pkg::tpc_chcfg_t c,
                                                     logic cp, logic [1:0] ck);
        if (c.els == tpc_pkg::ELS_OFF || ck == tpc_pkg::CLK_OFF) begin
            return tpc_pkg::FN_OFF;
        end
        if (cp) begin
            return tpc_pkg::FN_CPWM;
        end
        case (c.mode)
            tpc_pkg::MS_CAPT: return tpc_pkg::FN_CAPTURE;
            tpc_pkg::MS_COMP: return tpc_pkg::FN_COMPARE;
            default:          return tpc_pkg::FN_EPWM;
        endcase
    endfunction : chFunction

    always_comb begin
        s_d   = s_q;
        fn    = chFunction(cfg, tmr.center_align_select, tmr.clks);
        // sync[0] feeds sync[1] only; edges are seen between sync[1] and sync[2]
        s_d.sync = {s_q.sync[1:0], pinIn};
        rise  = s_q.sync[1] & ~s_q.sync[2];
        fall  = ~s_q.sync[1] & s_q.sync[2];
        match = tmr.step && (tmr.cnt == value);
        start = tmr.step && (tmr.cnt == tpc_pkg::CNT_ZERO);
        s_d.cap = 1'b0;
        case (fn)
            tpc_pkg::FN_CAPTURE: begin
                s_d.cap = ~blocked & ((cfg.els[0] & rise) | (cfg.els[1] & fall));
            end
            tpc_pkg::FN_COMPARE: begin
                // pin keeps its old level until the first match
                if (match) begin
                    case (cfg.els)
                        tpc_pkg::OC_TOGGLE: s_d.pin = ~s_q.pin;
                        tpc_pkg::OC_CLEAR:  s_d.pin = 1'b0;
                        tpc_pkg::OC_SET:    s_d.pin = 1'b1;
                        default:            s_d.pin = s_q.pin;
                    endcase
                end
            end
            tpc_pkg::FN_EPWM: begin
                if (match) begin
                    s_d.pin = cfg.els[0];
                end else if (start) begin
                    s_d.pin = ~cfg.els[0];
                end
            end
            tpc_pkg::FN_CPWM: begin
                if (match) begin
                    s_d.pin = tmr.upDir ? cfg.els[0] : ~cfg.els[0];
                end
            end
            default: begin
                s_d.pin = s_q.pin;
            end
        endcase
        s_d.oe = ~blocked && (fn != tpc_pkg::FN_OFF) && (fn != tpc_pkg::FN_CAPTURE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pinOut  = s_q.pin;
    assign pinOe   = s_q.oe;
    assign capture = s_q.cap;

    pin_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg.els == tpc_pkg::ELS_OFF || tmr.clks == tpc_pkg::CLK_OFF) |=> !pinOe)
        else $error("channel drives pin while released");
    epwm_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fn == tpc_pkg::FN_EPWM && cfg.els == 2'h2 && start && !match) |=> pinOut)
        else $error("pwm pin not high at period start");
    cap_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fn == tpc_pkg::FN_CAPTURE && !blocked && cfg.els == 2'h1 && rise) |=> capture)
        else $error("rising edge not captured");
    oc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fn == tpc_pkg::FN_COMPARE && !match) |=> $stable(pinOut))
        else $error("compare pin moved without match");
    cpwm_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fn == tpc_pkg::FN_CPWM && !blocked) |=> pinOe)
        else $error("center pwm pin not driven");

endmodule : tpc_channel
`default_nettype wire

// *** src/tpc_timer.sv ***
//
// Contract
// - ext clock on a shared pin stops that channel's pin I/O; timer use stays
// - channel releases pin when edge/level bits zero or clock source off
// - center-align set: every enabled channel drives center-aligned PWM
// - mode 0:0 is edge capture; edge/level bits choose rising, falling, either
// - capture input synchronised; four-cycle pulses always seen
// - mode 0:1 output compare toggles, clears or sets pin on match
// - toggle keeps previous pin level until first compare match
// - edge PWM B=1 A=0: high at count zero, low on match
// - edge PWM A=1: low at count zero, high on match
// - center PWM B=1 A=0: match clears counting up, sets counting down
// - center PWM A=1: match sets counting up, clears counting down
// - overflow flag bit 7 sets when counter wraps to zero after modulo
// - flag clears by reading it set, then writing zero to it
// - overflow during clearing restarts the sequence; flag stays set
// - writing one to flag ignored; reset zeroes all control fields
// - interrupt request while flag and enable bit 6 both set
// - bit 5 selects up counting or up/down center-aligned counting
// - bits 4-3 select stopped, bus, fixed or external clock
// - prescale bits 2-0 follow clock select; new value acts next cycle
// - prescale codes 0 to 7 divide by 1 to 128 in powers of two
// - up counting resumes from zero after reaching modulo
// - center mode counts up to modulo then down to zero
//
`timescale 1ns/1ps
`default_nettype none
module tpc_timer #(
    parameter int NCH      = 8,  // channel count, 1 to 8
    parameter int EXT_CHAN = 0   // channel sharing the ext clock pin
) (
    input  wire logic             clk,         // bus clock, 20 MHz
    input  wire logic             reset_n,     // async reset
    input  wire logic             cyc_i,       // wishbone cycle
    input  wire logic             stb_i,       // wishbone strobe
    input  wire logic             we_i,        // wishbone write
    input  wire logic [7:0]       adr_i,       // byte address
    input  wire logic [3:0]       sel_i,       // byte enables
    input  wire logic [31:0]      dat_i,       // write data
    output logic      [31:0]      dat_o,       // read data
    output logic                  ack_o,       // acknowledge
    input  wire logic             fixedClkIn,  // fixed-frequency clock
    input  wire logic             extClkPin,   // external clock pin
    input  wire logic [NCH-1:0]   chPinIn,     // channel pin levels
    output logic      [NCH-1:0]   chPinOut,    // channel pin drive
    output logic      [NCH-1:0]   chPinOe,     // channel pin enable
    output logic                  overflowIrq  // overflow request
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                               ack;
        logic [31:0]                        rdat;
        logic [7:0]                         sc;
        logic                               tofArm;
        logic                               irq;
        logic [15:0]                        cnt;
        logic                               upDir;
        logic                               step;
        logic [15:0]                        mod;
        logic [tpc_pkg::PRE_W-1:0]          pre;
        logic [2:0]                         fixSync;
        logic [2:0]                         extSync;
        logic [NCH-1:0][3:0]                chCfg;
        logic [NCH-1:0][15:0]               chVal;
    } tpc_state_t;

    tpc_state_t               s_q;
    tpc_state_t               s_d;
    logic                     acc;
    logic                     wr;
    logic                     rd;
    logic                     srcTick;
    logic                     tmrTick;
    logic                     ovf;
    logic                     cntWr;
    logic [15:0]              top;
    logic [NCH-1:0]           capStb;
    logic [NCH-1:0]           blocked;
    tpc_pkg::tpc_tmr_t        tmr;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] mergeHalf(logic [15:0] old, logic [31:0] d,
                                              logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : mergeHalf

    function automatic logic [tpc_pkg::PRE_W-1:0] divLimit(logic [2:0] ps);
        return 7'h7F >> (3'h7 - ps);
    endfunction : divLimit

    function automatic logic [7:0] chAdr(logic [7:0] base, int idx);
        return base + 8'(idx * tpc_pkg::ADR_STEP);
    endfunction : chAdr

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d     = s_q;
        acc     = cyc_i && stb_i && !s_q.ack;
        wr      = acc && we_i;
        rd      = acc && !we_i;
        s_d.ack = acc;
        cntWr   = wr && (adr_i == tpc_pkg::ADR_CNT);
        ovf     = 1'b0;
        tmrTick = 1'b0;

        // clock source; first sync stages feed only the second ones
        s_d.fixSync = {s_q.fixSync[1:0], fixedClkIn};
        s_d.extSync = {s_q.extSync[1:0], extClkPin};
        case (s_q.sc[tpc_pkg::SC_CLKS +: 2])
            tpc_pkg::CLK_BUS: srcTick = 1'b1;
            tpc_pkg::CLK_FIX: srcTick = s_q.fixSync[1] & ~s_q.fixSync[2];
            tpc_pkg::CLK_EXT: srcTick = s_q.extSync[1] & ~s_q.extSync[2];
            default:          srcTick = 1'b0;
        endcase

        // prescaler reads the live field, so a new value counts next cycle
        if (s_q.sc[tpc_pkg::SC_CLKS +: 2] == tpc_pkg::CLK_OFF) begin
            s_d.pre = '0;
        end else if (srcTick) begin
            if (s_q.pre >= divLimit(s_q.sc[tpc_pkg::SC_PS +: 3])) begin
                s_d.pre = '0;
                tmrTick = 1'b1;
            end else begin
                s_d.pre = s_q.pre + 7'h01;
            end
        end

        // counter; a modulo of zero runs free over the full range
        top      = (s_q.mod == tpc_pkg::MOD_RST) ? tpc_pkg::CNT_FREE : s_q.mod;
        s_d.step = 1'b0;
        if (!s_q.sc[tpc_pkg::SC_CENTER_ALIGN_SELECT]) begin
            s_d.upDir = 1'b1;
        end
        if (tmrTick) begin
            s_d.step = 1'b1;
            if (!s_q.sc[tpc_pkg::SC_CENTER_ALIGN_SELECT]) begin
                if (s_q.cnt >= top) begin
                    s_d.cnt = tpc_pkg::CNT_ZERO;
                    ovf     = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
            end else if (s_q.upDir) begin
                if (s_q.cnt >= top) begin
                    s_d.upDir = 1'b0;
                    s_d.cnt   = s_q.cnt - 16'h0001;
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
            end else begin
                if (s_q.cnt == tpc_pkg::CNT_ZERO) begin
                    s_d.upDir = 1'b1;
                    s_d.cnt   = s_q.cnt + 16'h0001;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                    ovf     = (s_q.cnt == 16'h0001);
                end
            end
        end
        if (cntWr) begin
            // any write restarts the count and the prescaler, and raises no overflow
            s_d.cnt   = tpc_pkg::CNT_ZERO;
            s_d.pre   = '0;
            s_d.upDir = 1'b1;
            s_d.step  = 1'b0;
            ovf       = 1'b0;
        end

        // register writes
        if (wr && sel_i[0] && adr_i == tpc_pkg::ADR_SC) begin
            s_d.sc[6:0] = dat_i[6:0];
            if (s_q.tofArm && !dat_i[tpc_pkg::SC_TOF]) begin
                s_d.sc[tpc_pkg::SC_TOF] = 1'b0;
            end
            s_d.tofArm = 1'b0;
        end
        if (wr && adr_i == tpc_pkg::ADR_MOD) begin
            s_d.mod = mergeHalf(s_q.mod, dat_i, sel_i);
        end
        for (int i = 0; i < NCH; i++) begin
            if (wr && sel_i[0] && adr_i == chAdr(tpc_pkg::ADR_CHCTL, i)) begin
                s_d.chCfg[i] = dat_i[3:0];
            end
            if (wr && adr_i == chAdr(tpc_pkg::ADR_CHVAL, i)) begin
                s_d.chVal[i] = mergeHalf(s_q.chVal[i], dat_i, sel_i);
            end
            if (capStb[i]) begin
                s_d.chVal[i] = s_q.cnt;
            end
        end

        // reading the flag while set arms the clear
        if (rd && adr_i == tpc_pkg::ADR_SC && s_q.sc[tpc_pkg::SC_TOF]) begin
            s_d.tofArm = 1'b1;
        end
        // an overflow wins over a clear and restarts the sequence
        if (ovf) begin
            s_d.sc[tpc_pkg::SC_TOF] = 1'b1;
            s_d.tofArm              = 1'b0;
        end
        s_d.irq = s_d.sc[tpc_pkg::SC_TOF] & s_d.sc[tpc_pkg::SC_OVERFLOW_IRQ_ENABLE];

        // read data; unmapped addresses answer zero
        s_d.rdat = 32'h0000_0000;
        if (rd) begin
            case (adr_i)
                tpc_pkg::ADR_SC:  s_d.rdat = 32'(s_q.sc);
                tpc_pkg::ADR_CNT: s_d.rdat = 32'(s_q.cnt);
                tpc_pkg::ADR_MOD: s_d.rdat = 32'(s_q.mod);
                default: begin
                    for (int i = 0; i < NCH; i++) begin
                        if (adr_i == chAdr(tpc_pkg::ADR_CHCTL, i)) begin
                            s_d.rdat = 32'(s_q.chCfg[i]);
                        end
                        if (adr_i == chAdr(tpc_pkg::ADR_CHVAL, i)) begin
                            s_d.rdat = 32'(s_q.chVal[i]);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q        <= '0;
            s_q.sc     <= tpc_pkg::SC_RST;
            s_q.mod    <= tpc_pkg::MOD_RST;
            s_q.upDir  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // channels
    // ****************************************
    assign tmr = '{cnt:   s_q.cnt,
                   step:  s_q.step,
                   upDir: s_q.upDir,
                   center_align_select: s_q.sc[tpc_pkg::SC_CENTER_ALIGN_SELECT],
                   clks:  s_q.sc[tpc_pkg::SC_CLKS +: 2]};

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            // the pin doubles as clock input; timer use without the pin stays
            assign blocked[g] = (g == EXT_CHAN) && (tmr.clks == tpc_pkg::CLK_EXT);
            tpc_channel u_ch (
                .clk     (clk),
                .reset_n (reset_n),
                .tmr     (tmr),
                .cfg     (s_q.chCfg[g]),
                .value   (s_q.chVal[g]),
                .blocked (blocked[g]),
                .pinIn   (chPinIn[g]),
                .pinOut  (chPinOut[g]),
                .pinOe   (chPinOe[g]),
                .capture (capStb[g])
            );
        end
    endgenerate

    assign dat_o       = s_q.rdat;
    assign ack_o       = s_q.ack;
    assign overflowIrq = s_q.irq;

    // ****************************************
    // checks
    // ****************************************
    ack_single_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");
    tof_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        ovf |=> s_q.sc[tpc_pkg::SC_TOF])
        else $error("overflow did not set flag");
    tof_noarm_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_q.sc[tpc_pkg::SC_TOF] && !s_q.tofArm) |=> s_q.sc[tpc_pkg::SC_TOF])
        else $error("flag cleared without prior read");
    tof_race_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ovf && wr && adr_i == tpc_pkg::ADR_SC) |=> s_q.sc[tpc_pkg::SC_TOF] && !s_q.tofArm)
        else $error("overflow lost during clear");
    irq_req_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(s_q.sc[tpc_pkg::SC_TOF]) && s_q.sc[tpc_pkg::SC_OVERFLOW_IRQ_ENABLE] |-> overflowIrq)
        else $error("interrupt request missing");
    cnt_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_OFF && !cntWr) |=> $stable(s_q.cnt))
        else $error("counter ran with clock off");
    up_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmrTick && !tmr.center_align_select && !cntWr && s_q.cnt == top) |=> s_q.cnt == 16'h0000)
        else $error("counter did not wrap at modulo");
    cpwm_turn_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmrTick && tmr.center_align_select && !cntWr && s_q.upDir && s_q.cnt == top) |=> !s_q.upDir)
        else $error("counter did not turn at modulo");
    div_two_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_BUS && s_q.sc[2:0] == 3'h1 && tmrTick)
        |=> !tmrTick)
        else $error("divide by two ticked twice");
    tof_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && sel_i[0] && adr_i == tpc_pkg::ADR_SC && s_q.tofArm
            && !dat_i[tpc_pkg::SC_TOF] && !ovf) |=> !s_q.sc[tpc_pkg::SC_TOF])
        else $error("armed clear did not clear flag");
    tof_arm_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && adr_i == tpc_pkg::ADR_SC && s_q.sc[tpc_pkg::SC_TOF] && !ovf) |=> s_q.tofArm)
        else $error("flag read did not arm clear");
    tof_one_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr && sel_i[0] && adr_i == tpc_pkg::ADR_SC && !s_q.sc[tpc_pkg::SC_TOF] && !ovf)
        |=> !s_q.sc[tpc_pkg::SC_TOF])
        else $error("writing one set the flag");
    irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
        overflowIrq == (s_q.sc[tpc_pkg::SC_TOF] && s_q.sc[tpc_pkg::SC_OVERFLOW_IRQ_ENABLE]))
        else $error("interrupt request not flag and enable");
    up_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmrTick && !tmr.center_align_select && !cntWr && s_q.cnt < top)
        |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("up count did not step by one");
    cpwm_up_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmrTick && tmr.center_align_select && !cntWr && !s_q.upDir && s_q.cnt == tpc_pkg::CNT_ZERO)
        |=> s_q.upDir)
        else $error("counter did not turn at zero");
    bus_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_BUS && s_q.sc[tpc_pkg::SC_PS +: 3] == 3'h0) |-> tmrTick)
        else $error("bus clock undivided did not tick");
    clk_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_OFF) |-> !tmrTick)
        else $error("tick with clock off");
    ext_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_EXT && srcTick) |=> (tmr.clks != tpc_pkg::CLK_EXT || !srcTick))
        else $error("external tick longer than one cycle");
    ovf_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        ovf |=> s_q.cnt == tpc_pkg::CNT_ZERO)
        else $error("overflow without return to zero");
    ext_block_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tmr.clks == tpc_pkg::CLK_EXT) |=> !chPinOe[EXT_CHAN])
        else $error("shared pin driven under external clock");
    dat_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        !ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside ack cycle");

endmodule : tpc_timer
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, resetN = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        extEn = 1'b0, pulse = 1'b0, ack, irq, external_clock_pin, fixClk, capPin;
    logic [7:0]  adr = 8'h00, pOut, pOe;
    logic [31:0] wdat = 32'h0000_0000, rdat, r;
    int          num_errors = 0, cmp_count = 0, h0, h1;
    always #25 clk = ~clk;
    tpc_timer DUT (.clk(clk), .reset_n(resetN), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .fixedClkIn(fixClk), .extClkPin(external_clock_pin), .chPinIn({5'h00, capPin, 2'h0}),
        .chPinOut(pOut), .chPinOe(pOe), .overflowIrq(irq));
    tpc_pins_model partner (.clk(clk), .extEn(extEn), .pulse(pulse), .external_clock_pin(external_clock_pin),
        .fixClk(fixClk), .capPin(capPin));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task pins(input int n);
        h0 = 0; h1 = 0;
        repeat (n) begin
            @(posedge clk);
            h0 += int'(pOut[0]); h1 += int'(pOut[1]);
        end
    endtask : pins
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // ****************************************
    // scenarios
    // ****************************************
    task t_flag;
        wb(0, 8'h00, 0); chk(r, 32'h0000_0000);
        wb(0, 8'hFC, 0); chk(r, 32'h0000_0000);
        wb(1, 8'h08, 32'h0000_0004); wb(1, 8'h00, 32'h0000_0008);
        repeat (10) @(posedge clk);
        wb(0, 8'h00, 0); chk(r, 32'h0000_0088);
        chk({31'h0, irq}, 32'h0);
        wb(1, 8'h00, 32'h0000_00C0); wb(0, 8'h00, 0); chk(r, 32'h0000_00C0);
        chk({31'h0, irq}, 32'h1);
        wb(1, 8'h00, 32'h0000_0040); wb(0, 8'h00, 0); chk(r, 32'h0000_0040);
        chk({31'h0, irq}, 32'h0);
        wb(1, 8'h00, 32'h0000_0048); repeat (10) @(posedge clk);
        wb(0, 8'h00, 0); repeat (10) @(posedge clk);
        wb(1, 8'h00, 32'h0000_0040); wb(0, 8'h00, 0); chk(r, 32'h0000_00C0);
        $display("test flag done");
    endtask : t_flag
    task t_pwm;
        wb(1, 8'h08, 32'h0000_0008); wb(1, 8'h40, 32'h0000_0005); wb(1, 8'h44, 32'h0000_0005);
        wb(1, 8'h20, 32'h0000_000A); wb(1, 8'h24, 32'h0000_0009); chk(pOe, 8'h00);
        wb(1, 8'h00, 32'h0000_0008); repeat (12) @(posedge clk);
        pins(18); chk(h0, 10); chk(h1, 8); chk(pOe, 8'h03);
        // compare set on channel 0, toggle on channel 1: one toggle per period
        wb(1, 8'h20, 32'h0000_0007); wb(1, 8'h24, 32'h0000_0005); repeat (12) @(posedge clk);
        pins(18); chk(h0, 18); chk(h1, 9); chk(pOe, 8'h03);
        // mode bits left at capture: center-aligned must override them
        wb(1, 8'h20, 32'h0000_0002); wb(1, 8'h24, 32'h0000_0001);
        wb(1, 8'h00, 32'h0000_0028); repeat (20) @(posedge clk);
        pins(32); chk(h0, 20); chk(h1, 12); chk(pOe, 8'h03);
        $display("test pwm done");
    endtask : t_pwm
    task t_capt;
        wb(1, 8'h08, 0); wb(1, 8'h00, 32'h0000_0008); wb(1, 8'h48, 0);
        wb(1, 8'h28, 32'h0000_0001); repeat (20) @(posedge clk);
        pulse <= 1'b1; @(posedge clk); pulse <= 1'b0;
        repeat (12) @(posedge clk);
        wb(0, 8'h48, 0); chk({31'h0, r != 0}, 32'h1); chk(pOe[2], 1'b0);
        wb(1, 8'h20, 32'h0000_000A); wb(1, 8'h00, 32'h0000_0018); extEn <= 1'b1;
        wb(1, 8'h04, 0); repeat (80) @(posedge clk); wb(0, 8'h04, 0);
        chk({31'h0, r >= 9 && r <= 12}, 32'h1); chk(pOe[0], 1'b0);
        extEn <= 1'b0;
        // fixed clock every four cycles, divided by two
        wb(1, 8'h00, 32'h0000_0011); wb(1, 8'h04, 0);
        repeat (80) @(posedge clk); wb(0, 8'h04, 0);
        chk({31'h0, r >= 9 && r <= 12}, 32'h1);
        $display("test capture done");
    endtask : t_capt
    initial begin
        repeat (3) @(posedge clk);
        resetN <= 1'b1;
        @(posedge clk);
        t_flag;
        t_pwm;
        t_capt;
        end_sim;
    end
    initial begin
        #(50 * 5000);
        num_errors++;
        end_sim;
    end
endmodule : testbench
`default_nettype wire

// *** verif/tpc_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_pins_model (
    input  wire logic clk,    // bus clock
    input  wire logic extEn,  // run the external clock
    input  wire logic pulse,  // start a capture pulse
    output logic      external_clock_pin, // external clock pin
    output logic      fixClk, // fixed-frequency clock
    output logic      capPin  // capture pin level
);
    logic [3:0] div_q = 4'h0;
    logic [2:0] capCnt_q = 3'h0;
    // ****************************************
    // clocks and capture pulse
    // ****************************************
    always_ff @(posedge clk) begin
        div_q <= div_q + 4'h1;
        external_clock_pin <= extEn & div_q[2];
        fixClk <= div_q[1];
        // pulse kept at the shortest width that must still be caught
        capCnt_q <= pulse ? 3'h4 : (capCnt_q != 3'h0) ? capCnt_q - 3'h1 : 3'h0;
        capPin <= (capCnt_q != 3'h0);
    end
endmodule : tpc_pins_model
`default_nettype wire
